// File: shared/ipa_regs.svh
// Function
// [RULE1] Indirect space: 32 devices, 65536 16-bit registers
// [RULE2] Portal reached via control Dh, window Eh
// [RULE3] Control bits 15:14 select portal operation
// [RULE4] Control bits 4:0 device; 13:5 reserved
// [RULE5] Mode 00 window holds register address
// [RULE6] Data modes read/write selected indirect register
// [RULE7] Mode 10 increments address after reads, writes
// [RULE8] Mode 11 increments after writes only
// [RULE9] Portal registers RW, reset to zero
// [RULE10] Host: address, mode 00, address, data mode
// [RULE11] Host may stream reads in mode 10
// [RULE12] Burst interval 8 or 16 ms from device 0
// [RULE13] Low timing word: 4000h 8 ms, 1A80h 16 ms
// [RULE14] High timing word: 0003h 8 ms, 0006h 16 ms
// [RULE15] Host sets both words to same interval
// [RULE16] Increment wraps modulo 65536, after access
// [RULE17] Unsupported indirect addresses: writes ignored, read zero
`ifndef IPA_REGS_SVH
`define IPA_REGS_SVH

`define IPA_STD_CTRL_ADDR 5'h0d
`define IPA_STD_WIN_ADDR 5'h0e
`define IPA_CTRL_OP_HI 15
`define IPA_CTRL_OP_LO 14
`define IPA_CTRL_DEV_HI 4
`define IPA_CTRL_DEV_LO 0
`define IPA_CTRL_RSVD_W 9
`define IPA_DEV_COUNT 32
`define IPA_IND_DEV_TIMING 5'h00
`define IPA_IND_BURST_LO 16'h0003
`define IPA_IND_BURST_HI 16'h0004
`define IPA_BURST_LO_8MS 16'h4000
`define IPA_BURST_LO_16MS 16'h1a80
`define IPA_BURST_HI_8MS 16'h0003
`define IPA_BURST_HI_16MS 16'h0006
`define IPA_BURST_8MS_US 8000
`define IPA_BURST_16MS_US 16000
`define IPA_CLK_MHZ 125
`define IPA_BURST_CNT_W 22

`endif

// File: shared/ipa_pkg.sv
package ipa_pkg;

  typedef enum logic [1:0] {
    IPA_OP_ADDR = 2'h0,
    IPA_OP_DATA = 2'h1,
    IPA_OP_INC_RW = 2'h2,
    IPA_OP_INC_W = 2'h3
  } ipa_op_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [15:0] wdata;
  } ipa_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } ipa_rsp_t;

endpackage : ipa_pkg

// File: logic/ipa_portal.sv
`timescale 1ns/1ps
`include "ipa_regs.svh"

module ipa_portal #(
  parameter int unsigned BURST_8MS_CYCLES = `IPA_BURST_8MS_US * `IPA_CLK_MHZ,
  parameter int unsigned BURST_16MS_CYCLES = `IPA_BURST_16MS_US * `IPA_CLK_MHZ,
  parameter int unsigned CNT_W = `IPA_BURST_CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire ipa_pkg::ipa_req_t mgmt_req,
  output ipa_pkg::ipa_rsp_t mgmt_rsp,
  output logic flp_burst,
  output logic burst_is_16ms
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (BURST_8MS_CYCLES < 2 || BURST_16MS_CYCLES < 2 ||
      BURST_8MS_CYCLES >= (64'd1 << CNT_W) || BURST_16MS_CYCLES >= (64'd1 << CNT_W)) begin : g_bad
    $error("ipa_portal: burst counts do not fit the counter");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  ipa_pkg::ipa_op_t op_reg;
  logic [4:0] dev_reg;
  logic [15:0] addr_mem [`IPA_DEV_COUNT];
  logic [15:0] burst_lo_reg;
  logic [15:0] burst_hi_reg;
  ipa_pkg::ipa_rsp_t rsp_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic pulse_reg;
  logic is16_reg;
  logic [15:0] addr_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Any nonzero operation code turns the window into data
  function automatic logic op_is_data(input ipa_pkg::ipa_op_t op);
    return op != ipa_pkg::IPA_OP_ADDR;
  endfunction : op_is_data

  // Sixteen-bit wrap is intended, never a carry into bit 16
  function automatic logic [15:0] addr_plus_one(input logic [15:0] a);
    return a + 16'h0001;
  endfunction : addr_plus_one

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire acc = mgmt_req.valid;
  wire wr = acc & mgmt_req.write;
  wire rd = acc & ~mgmt_req.write;
  wire hit_ctrl = (mgmt_req.addr == `IPA_STD_CTRL_ADDR); // [RULE2]
  wire hit_win = (mgmt_req.addr == `IPA_STD_WIN_ADDR); // [RULE2]
  wire [15:0] cur_addr = addr_mem[dev_reg]; // [RULE1]
  wire data_mode = op_is_data(op_reg); // [RULE5]
  wire in_dev0 = (dev_reg == `IPA_IND_DEV_TIMING);
  wire sel_lo = in_dev0 && (cur_addr == `IPA_IND_BURST_LO); // [RULE17]
  wire sel_hi = in_dev0 && (cur_addr == `IPA_IND_BURST_HI); // [RULE17]
  // Unsupported indirect registers read as zero
  wire [15:0] ind_rdata = sel_lo ? burst_lo_reg : (sel_hi ? burst_hi_reg : 16'h0000); // [RULE6]
  wire [15:0] win_rdata = data_mode ? ind_rdata : cur_addr; // [RULE5] [RULE6]
  // Reserved control bits are never stored, so they read zero
  wire [15:0] ctrl_rdata = {op_reg, `IPA_CTRL_RSVD_W'(0), dev_reg}; // [RULE3] [RULE4]
  wire [15:0] rd_mux = hit_ctrl ? ctrl_rdata : (hit_win ? win_rdata : 16'h0000);
  wire win_acc = acc && hit_win && data_mode;
  wire inc_rw = win_acc && (op_reg == ipa_pkg::IPA_OP_INC_RW); // [RULE7]
  wire inc_w = win_acc && wr && (op_reg == ipa_pkg::IPA_OP_INC_W); // [RULE8]
  wire do_inc = inc_rw || inc_w;
  wire addr_wr = wr && hit_win && !data_mode; // [RULE5]
  wire ind_wr = wr && hit_win && data_mode; // [RULE6]
  wire ctrl_wr = wr && hit_ctrl; // [RULE9]

  // Increment uses the address the access itself just used, wrapping in 16 bits
  always_comb begin
    if (addr_wr) begin
      addr_next = mgmt_req.wdata;
    end else if (do_inc) begin
      addr_next = addr_plus_one(cur_addr); // [RULE16]
    end else begin
      addr_next = cur_addr;
    end
  end

  // ----------------------------------------
  // Portal registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      op_reg <= ipa_pkg::IPA_OP_ADDR; // [RULE9]
      dev_reg <= 5'h00;
    end else if (ctrl_wr) begin
      op_reg <= ipa_pkg::ipa_op_t'(mgmt_req.wdata[`IPA_CTRL_OP_HI:`IPA_CTRL_OP_LO]); // [RULE3]
      dev_reg <= mgmt_req.wdata[`IPA_CTRL_DEV_HI:`IPA_CTRL_DEV_LO]; // [RULE4]
    end
  end

  // One stored address per device; only the selected one moves
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < `IPA_DEV_COUNT; i++) begin
        addr_mem[i] <= 16'h0000; // [RULE9]
      end
    end else begin
      addr_mem[dev_reg] <= addr_next; // [RULE7] [RULE8]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      burst_lo_reg <= `IPA_BURST_LO_8MS; // [RULE13]
      burst_hi_reg <= `IPA_BURST_HI_8MS; // [RULE14]
    end else begin
      if (ind_wr && sel_lo) begin
        burst_lo_reg <= mgmt_req.wdata; // [RULE13]
      end
      if (ind_wr && sel_hi) begin
        burst_hi_reg <= mgmt_req.wdata; // [RULE14]
      end
    end
  end

  // Every request answered one cycle later; writes answer with zero data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.valid <= acc;
      rsp_reg.rdata <= rd ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------
  // Burst interval timer
  // ----------------------------------------
  // Mixed or reserved encodings fall back to 8 ms rather than stall
  wire is16 = (burst_lo_reg == `IPA_BURST_LO_16MS) && (burst_hi_reg == `IPA_BURST_HI_16MS); // [RULE15]
  wire [CNT_W-1:0] lim_m1 = is16 ? CNT_W'(BURST_16MS_CYCLES - 1) : CNT_W'(BURST_8MS_CYCLES - 1);
  wire cnt_done = (cnt_reg >= lim_m1); // [RULE12]

  always_comb begin
    cnt_next = cnt_done ? '0 : cnt_reg + CNT_W'(1);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
      is16_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pulse_reg <= cnt_done; // [RULE12]
      is16_reg <= is16;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mgmt_rsp = rsp_reg;
  assign flp_burst = pulse_reg;
  assign burst_is_16ms = is16_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Gap counter measures every pulse-to-pulse distance
  logic [CNT_W-1:0] gap_reg;
  logic seen_reg;
  logic chg_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
      chg_reg <= 1'b0;
    end else begin
      gap_reg <= pulse_reg ? '0 : gap_reg + CNT_W'(1);
      seen_reg <= seen_reg | pulse_reg;
      chg_reg <= pulse_reg ? 1'b0 : (chg_reg | (is16 != is16_reg));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  rsp_one_cycle_a: assert property (acc |=> mgmt_rsp.valid ##1 (mgmt_rsp.valid == $past(acc))) // [RULE6]
    else $error("answer not one cycle after request");
  ctrl_store_a: assert property (ctrl_wr |=> (mgmt_rsp.valid && op_reg == $past(mgmt_req.wdata[15:14])
      && dev_reg == $past(mgmt_req.wdata[4:0]))) // [RULE3] [RULE4]
    else $error("control write not stored");
  ctrl_read_a: assert property ((rd && hit_ctrl) |=> mgmt_rsp.rdata[13:5] == 9'h000
      && mgmt_rsp.rdata[4:0] == dev_reg) // [RULE4]
    else $error("control readback wrong");
  addr_mode_a: assert property ((rd && hit_win && !data_mode) |=> mgmt_rsp.rdata == $past(cur_addr)) // [RULE5]
    else $error("address mode read wrong");
  inc_rw_a: assert property ((acc && hit_win && op_reg == ipa_pkg::IPA_OP_INC_RW && !ctrl_wr)
      |=> cur_addr == addr_plus_one($past(cur_addr))) // [RULE7] [RULE16]
    else $error("mode 10 did not increment");
  inc_wonly_a: assert property ((rd && hit_win && op_reg == ipa_pkg::IPA_OP_INC_W)
      |=> cur_addr == $past(cur_addr)) // [RULE8]
    else $error("mode 11 read moved address");
  inc_wr_a: assert property ((wr && hit_win && op_reg == ipa_pkg::IPA_OP_INC_W)
      |=> cur_addr == addr_plus_one($past(cur_addr))) // [RULE8]
    else $error("mode 11 write did not increment");
  no_inc_a: assert property ((acc && hit_win && op_reg == ipa_pkg::IPA_OP_DATA)
      |=> cur_addr == $past(cur_addr)) // [RULE6]
    else $error("mode 01 moved address");
  unsup_zero_a: assert property ((rd && hit_win && data_mode && !sel_lo && !sel_hi)
      |=> mgmt_rsp.rdata == 16'h0000) // [RULE17]
    else $error("unsupported register read nonzero");
  burst_gap_a: assert property ((pulse_reg && seen_reg && !chg_reg && is16 == is16_reg)
      |-> gap_reg == lim_m1) // [RULE12]
    else $error("burst interval wrong");
  reset_vals_a: assert property (@(posedge clk) disable iff (1'b0) !resetn |=> (op_reg ==
      ipa_pkg::IPA_OP_ADDR && burst_lo_reg == `IPA_BURST_LO_8MS
      && burst_hi_reg == `IPA_BURST_HI_8MS && !mgmt_rsp.valid)) // [RULE9] [RULE13] [RULE14]
    else $error("reset values wrong");
  rst_portal_a: assert property (@(posedge clk) disable iff (1'b0) !resetn |=> (dev_reg == 5'h00
      && cur_addr == 16'h0000 && !flp_burst && !burst_is_16ms)) // [RULE9]
    else $error("portal reset state wrong");

  // ----------------------------------------
  // Data path checks
  // ----------------------------------------
  lo_read_a: assert property ((rd && hit_win && data_mode && sel_lo)
      |=> mgmt_rsp.rdata == $past(burst_lo_reg)) // [RULE6]
    else $error("low timing word read wrong");
  hi_read_a: assert property ((rd && hit_win && data_mode && sel_hi)
      |=> mgmt_rsp.rdata == $past(burst_hi_reg)) // [RULE6]
    else $error("high timing word read wrong");
  other_dev_a: assert property ((rd && hit_win && data_mode && !in_dev0)
      |=> mgmt_rsp.rdata == 16'h0000) // [RULE17]
    else $error("other device read nonzero");
  lo_write_a: assert property ((ind_wr && sel_lo)
      |=> burst_lo_reg == $past(mgmt_req.wdata)) // [RULE13]
    else $error("low timing word not written");
  hi_write_a: assert property ((ind_wr && sel_hi)
      |=> burst_hi_reg == $past(mgmt_req.wdata)) // [RULE14]
    else $error("high timing word not written");
  unsup_write_a: assert property ((ind_wr && !sel_lo && !sel_hi)
      |=> $stable(burst_lo_reg) && $stable(burst_hi_reg)) // [RULE17]
    else $error("unsupported write changed a timing word");
  read_keep_a: assert property (rd
      |=> $stable(burst_lo_reg) && $stable(burst_hi_reg)) // [RULE6]
    else $error("read changed a timing word");
  addr_write_a: assert property (addr_wr
      |=> cur_addr == $past(mgmt_req.wdata)) // [RULE5]
    else $error("register address not stored");
  addr_hold_a: assert property ((rd && hit_win && !data_mode)
      |=> cur_addr == $past(cur_addr)) // [RULE5]
    else $error("address mode read moved address");
  // Writes answer with zero so a host never sees stale data
  write_zero_a: assert property (wr
      |=> mgmt_rsp.valid && mgmt_rsp.rdata == 16'h0000) // [RULE6]
    else $error("write answer not zero");
  rsp_idle_a: assert property (!acc
      |=> !mgmt_rsp.valid) // [RULE6]
    else $error("answer without request");
  unmapped_a: assert property ((acc && !hit_ctrl && !hit_win)
      |=> mgmt_rsp.rdata == 16'h0000) // [RULE2]
    else $error("unmapped address answered nonzero");
  mode_hold_a: assert property (!ctrl_wr
      |=> $stable(op_reg)) // [RULE3]
    else $error("mode changed without control write");
  dev_hold_a: assert property (!ctrl_wr
      |=> $stable(dev_reg)) // [RULE4]
    else $error("device changed without control write");

  // ----------------------------------------
  // Timer checks
  // ----------------------------------------
  pulse_single_a: assert property (flp_burst
      |=> !flp_burst) // [RULE12]
    else $error("burst pulse longer than one cycle");
  // Mixed settings must report 8 ms
  level_follows_a: assert property (burst_is_16ms
      == $past(is16)) // [RULE13] [RULE14]
    else $error("interval level wrong");
  done_pulse_a: assert property (cnt_done
      |=> flp_burst && cnt_reg == '0) // [RULE12]
    else $error("burst not issued at count end");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  seq_read_c: cover property ((rd && hit_win && op_reg == ipa_pkg::IPA_OP_INC_RW)
      ##2 (rd && hit_win && op_reg == ipa_pkg::IPA_OP_INC_RW));
  burst8_c: cover property (pulse_reg && !is16_reg);
  ind_write_c: cover property (ind_wr && sel_lo);
  burst16_c: cover property (pulse_reg && is16_reg);
  addr_set_c: cover property (addr_wr);

endmodule : ipa_portal

// File: verif/ipa_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Management host model
// ----------------------------------------
module ipa_host (
  input wire logic clk,
  output ipa_pkg::ipa_req_t mgmt_req,
  input wire ipa_pkg::ipa_rsp_t mgmt_rsp
);
  initial mgmt_req = '0;
  // Released fields show inverted data, never a stale copy
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic ok, output logic [15:0] q);
    @(posedge clk);
    mgmt_req <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge clk);
    mgmt_req <= '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    #1;
    ok = mgmt_rsp.valid;
    q = mgmt_rsp.rdata;
  endtask : access
endmodule : ipa_host

// File: verif/indirect_mmd_access_portal_test.sv
`timescale 1ns/1ps
module indirect_mmd_access_portal_test;
  localparam logic [4:0] CTRL = 5'h0d;
  localparam logic [4:0] WIN = 5'h0e;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ipa_pkg::ipa_req_t mgmt_req;
  ipa_pkg::ipa_rsp_t mgmt_rsp;
  logic flp_burst;
  logic burst_is_16ms;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  // Short burst counts keep the run brief
  ipa_portal #(.BURST_8MS_CYCLES(20), .BURST_16MS_CYCLES(40), .CNT_W(22)) ipa_portal_i (
    .clk(clk), .resetn(resetn), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
    .flp_burst(flp_burst), .burst_is_16ms(burst_is_16ms));
  ipa_host ipa_host_i (.clk(clk), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic report_and_stop;
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic ok;
    logic [15:0] q;
    ipa_host_i.access(1'b1, a, d, ok, q);
    chk({15'h0, ok}, 16'h1);
    chk(q, 16'h0000);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    logic ok;
    logic [15:0] q;
    ipa_host_i.access(1'b0, a, 16'h0, ok, q);
    chk({15'h0, ok}, 16'h1);
    chk(q, exp);
  endtask : rd
  task automatic select(input logic [15:0] ctl, input logic [15:0] reg_addr);
    wr(CTRL, ctl & 16'h001f);
    wr(WIN, reg_addr);
    wr(CTRL, ctl);
  endtask : select
  task automatic burst_gap(input int exp);
    int n;
    n = 0;
    @(posedge clk iff flp_burst === 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (flp_burst !== 1'b1 && n < 100);
    chk(n[15:0], exp[15:0]);
  endtask : burst_gap
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values;
    rd(CTRL, 16'h0000);
    rd(WIN, 16'h0000);
    rd(5'h05, 16'h0000);
    select(16'h4000, 16'h0003);
    rd(WIN, 16'h4000);
    rd(WIN, 16'h4000);
    select(16'h4000, 16'h0004);
    rd(WIN, 16'h0003);
  endtask : reset_values
  task automatic control_fields;
    wr(CTRL, 16'hffe2);
    rd(CTRL, 16'hc002);
    select(16'h0002, 16'h0010);
    rd(WIN, 16'h0010);
    wr(CTRL, 16'h0000);
    rd(WIN, 16'h0004);
  endtask : control_fields
  task automatic stream_reads;
    select(16'h8000, 16'h0003);
    rd(WIN, 16'h4000);
    rd(WIN, 16'h0003);
    rd(WIN, 16'h0000);
    wr(CTRL, 16'h0000);
    rd(WIN, 16'h0006);
  endtask : stream_reads
  task automatic write_increment;
    select(16'hc000, 16'h0003);
    rd(WIN, 16'h4000);
    rd(WIN, 16'h4000);
    wr(WIN, 16'h1a80);
    wr(WIN, 16'h0006);
    wr(CTRL, 16'h0000);
    rd(WIN, 16'h0005);
    chk({15'h0, burst_is_16ms}, 16'h1);
    burst_gap(40);
    select(16'hc000, 16'h0003);
    wr(WIN, 16'h4000);
    wr(WIN, 16'h0003);
    burst_gap(20);
    chk({15'h0, burst_is_16ms}, 16'h0);
  endtask : write_increment
  task automatic address_wrap;
    select(16'h8000, 16'hffff);
    rd(WIN, 16'h0000);
    wr(CTRL, 16'h0000);
    rd(WIN, 16'h0000);
  endtask : address_wrap
  task automatic reset_midrun;
    select(16'hc000, 16'h0003);
    wr(WIN, 16'h1a80);
    wr(WIN, 16'h0006);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(CTRL, 16'h0000);
    rd(WIN, 16'h0000);
    chk({15'h0, burst_is_16ms}, 16'h0);
    select(16'h4000, 16'h0003);
    rd(WIN, 16'h4000);
  endtask : reset_midrun
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reset_values;
    control_fields;
    stream_reads;
    write_increment;
    address_wrap;
    reset_midrun;
    report_and_stop;
  end
endmodule : indirect_mmd_access_portal_test
